// File: verilog/omc_top.sv
`timescale 1ns/10ps
// operating mode controller top: five mode state machine
// assumes all inputs synchronous; events are one-cycle pulses except the idle_allowed level
module omc_top
    import omc_pkg::*;
(
    // clocking
    input  wire logic               clock,
    input  wire logic               resetn,
    // supply and variant
    input  wire logic               supply_ok,
    input  wire logic               backup_supply_rail,
    input  wire logic [1:0]         slow_variant,
    // events and host command
    input  wire omc_pkg::omc_evt_t  evt,
    input  wire omc_pkg::omc_cmd_t  power_saving_command,
    // state
    output omc_pkg::omc_mode_t      mode,
    output logic [1:0]              psv_setting,
    output omc_pkg::omc_status_t    status
);
    import omc_pkg::*;

    typedef struct packed {
        omc_mode_t   mode;
        logic [1:0]  psv;
        logic        flow;
        omc_status_t stat;
    } omc_top_st_t;

    omc_top_st_t st_q, st_d;
    logic        on_cause;
    logic        idle_wake;
    omc_clk_t    clk_sel;
    logic        ext_a;
    logic        ext_b;
    logic        rtc_run;

    omc_wake u_wake (
        .clock           (clock),
        .resetn          (resetn),
        .evt             (evt),
        .psv_setting     (st_q.psv),
        .switch_on_cause (on_cause),
        .idle_wake       (idle_wake)
    );

    // clock select looks at next mode so status lines up with mode
    omc_clksel u_clksel (
        .mode               (st_d.mode),
        .slow_variant       (slow_variant),
        .backup_supply_rail (backup_supply_rail),
        .core_clk           (clk_sel),
        .ext_a_used         (ext_a),
        .ext_b_used         (ext_b),
        .rtc_running        (rtc_run)
    );

    function automatic logic cts_n_of(omc_mode_t m, logic [1:0] psv, logic flow);
        logic en;
        en = (m == OMC_ACTIVE) || (m == OMC_CONNECTED);
        // without flow control cts stays asserted, uart state unseen
        cts_n_of = flow ? ~en : 1'b0;
        if (psv == OMC_PSV_OFF)
            cts_n_of = 1'b0;
    endfunction

    always_comb
    begin
        st_d = st_q;
        if (!supply_ok)
        begin
            st_d.mode = OMC_NOT_POWERED;
        end
        else
        begin
            unique case (st_q.mode)
                OMC_NOT_POWERED: st_d.mode = OMC_ACTIVE;
                OMC_POWER_OFF:
                    if (on_cause)
                        st_d.mode = OMC_ACTIVE;
                OMC_ACTIVE:
                    if (evt.power_off_event)
                        st_d.mode = OMC_POWER_OFF;
                    else if (evt.call_start)
                        st_d.mode = OMC_CONNECTED;
                    else if (st_q.psv != OMC_PSV_OFF && evt.idle_allowed)
                        st_d.mode = OMC_IDLE;
                OMC_IDLE:
                    if (evt.power_off_event)
                        st_d.mode = OMC_POWER_OFF;
                    else if (idle_wake || evt.call_start)
                        st_d.mode = OMC_ACTIVE;
                OMC_CONNECTED:
                    if (evt.call_end)
                        st_d.mode = OMC_ACTIVE;
            endcase
        end
        // power saving cleared whenever the next mode is not-powered or power-off
        if (st_d.mode == OMC_NOT_POWERED || st_d.mode == OMC_POWER_OFF)
        begin
            st_d.psv  = OMC_PSV_RESET;
            st_d.flow = 1'b0;
        end
        else if (power_saving_command.valid)
        begin
            st_d.psv  = power_saving_command.setting;
            st_d.flow = power_saving_command.flow_ctrl;
        end
        st_d.stat.core_clk        = clk_sel;
        st_d.stat.slow_ext_a_used = ext_a;
        st_d.stat.slow_ext_b_used = ext_b;
        st_d.stat.rtc_running     = rtc_run;
        st_d.stat.app_if_enable   = (st_d.mode == OMC_ACTIVE
                                     || st_d.mode == OMC_CONNECTED)
                                    && st_d.psv == OMC_PSV_OFF;
        st_d.stat.uart_cts_n      = cts_n_of(st_d.mode, st_d.psv, st_d.flow);
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            st_q      <= '0;
            st_q.mode <= OMC_NOT_POWERED;
        end
        else
            st_q <= st_d;
    end

    assign mode        = st_q.mode;
    assign psv_setting = st_q.psv;
    assign status      = st_q.stat;

    a_supply_loss: assert property (@(posedge clock) disable iff (!resetn)
        !supply_ok |=> mode == OMC_NOT_POWERED)
        else $error("supply loss did not give not-powered");
    a_np_start: assert property (@(posedge clock) disable iff (!resetn)
        mode == OMC_NOT_POWERED && supply_ok |=> mode == OMC_ACTIVE)
        else $error("supply applied did not give active");
    a_off_event: assert property (@(posedge clock) disable iff (!resetn)
        supply_ok && mode == OMC_ACTIVE && evt.power_off_event |=> mode == OMC_POWER_OFF)
        else $error("power-off event ignored");
    sequence s_wake_cause;
        supply_ok && mode == OMC_POWER_OFF && (evt.power_on_request_pin || evt.rtc_alarm);
    endsequence
    a_off_wake: assert property (@(posedge clock) disable iff (!resetn)
        s_wake_cause ##1 supply_ok |=> mode == OMC_ACTIVE)
        else $error("power-off did not wake");
    a_idle_clk: assert property (@(posedge clock) disable iff (!resetn)
        mode == OMC_IDLE |-> status.core_clk == OMC_CLK_SLOW)
        else $error("idle not on slow reference");
    a_fast_clk: assert property (@(posedge clock) disable iff (!resetn)
        mode == OMC_CONNECTED |-> status.core_clk == OMC_CLK_FAST)
        else $error("connected not on fast reference");
    a_psv_off: assert property (@(posedge clock) disable iff (!resetn)
        $rose(mode == OMC_ACTIVE) && $past(mode) == OMC_POWER_OFF |-> psv_setting == OMC_PSV_OFF)
        else $error("power saving kept across switch-on");
    a_no_idle: assert property (@(posedge clock) disable iff (!resetn)
        mode == OMC_ACTIVE && psv_setting == OMC_PSV_OFF && !power_saving_command.valid
        |=> mode != OMC_IDLE)
        else $error("idle entered with power saving off");
    a_call: assert property (@(posedge clock) disable iff (!resetn)
        supply_ok && mode == OMC_CONNECTED && evt.call_end |=> mode == OMC_ACTIVE)
        else $error("call end did not return to active");
    a_idle_if: assert property (@(posedge clock) disable iff (!resetn)
        mode == OMC_IDLE |-> !status.app_if_enable)
        else $error("interface open in idle");
endmodule

// File: verilog/omc_pkg.sv
// operating mode controller package: modes, clock sources, carriers
// assumes a single 100 MHz clock and synchronous control inputs
// Notes on behaviour
// - supply loss forces not-powered from any mode
// - not-powered ignores power-on, reset, alarm
// - supply applied: not-powered goes to active
// - power-off event in active enters power-off
// - power-off wakes on pin, reset or alarm
// - supply loss in power-off gives not-powered
// - idle runs core from slow reference
// - slow source chosen by device variant
// - active and connected use fast reference
// - power saving lets active drop to idle
// - power saving disabled after every switch-on
// - idle wakes on paging, uart window, alarm
// - cts shows serial enable per settings
// - call start connects, call end returns active
// - rtc runs unpowered only with backup rail
// - idle blocks application interface traffic
// - active and connected allow interface traffic only with power saving off
package omc_pkg;
    typedef enum logic [2:0] {
        OMC_NOT_POWERED,
        OMC_POWER_OFF,
        OMC_IDLE,
        OMC_ACTIVE,
        OMC_CONNECTED
    } omc_mode_t;

    // core clock source select
    typedef enum logic [1:0] {
        OMC_CLK_NONE,
        OMC_CLK_FAST,
        OMC_CLK_SLOW
    } omc_clk_t;

    // slow reference variant
    localparam logic [1:0] OMC_SLOW_INTERNAL = 2'h0;
    localparam logic [1:0] OMC_SLOW_EXT_A    = 2'h1;
    localparam logic [1:0] OMC_SLOW_EXT_B    = 2'h2;

    localparam int OMC_SLOW_KHZ   = 32;
    localparam int OMC_SLOW_B_KHZ = 20;
    localparam int OMC_FAST_KHZ   = 26000;

    // power saving settings
    localparam logic [1:0] OMC_PSV_OFF    = 2'h0;
    localparam logic [1:0] OMC_PSV_UART_1 = 2'h1;
    localparam logic [1:0] OMC_PSV_RESET  = OMC_PSV_OFF;

    // events from the surrounding system, one cycle pulses except the idle_allowed level
    typedef struct packed {
        logic power_on_request_pin;
        logic reset_request;
        logic rtc_alarm;
        logic power_off_event;
        logic call_start;
        logic call_end;
        logic paging_wake;
        logic uart_wake;
        logic idle_allowed;
    } omc_evt_t;

    // power saving command strobe with its setting
    typedef struct packed {
        logic       valid;
        logic [1:0] setting;
        logic       flow_ctrl;
    } omc_cmd_t;

    typedef struct packed {
        omc_clk_t core_clk;
        logic     slow_ext_a_used;
        logic     slow_ext_b_used;
        logic     app_if_enable;
        logic     uart_cts_n;
        logic     rtc_running;
    } omc_status_t;
endpackage

// File: verilog/omc_wake.sv
`timescale 1ns/10ps
// wake cause merge for power-off and idle
// assumes event pulses synchronous to clock
module omc_wake
    import omc_pkg::*;
(
    // clocking
    input  wire logic           clock,
    input  wire logic           resetn,
    // causes
    input  wire omc_pkg::omc_evt_t evt,
    input  wire logic [1:0]     psv_setting,
    // results
    output logic                switch_on_cause,
    output logic                idle_wake
);
    import omc_pkg::*;

    typedef struct packed {
        logic on;
        logic wake;
    } omc_wake_st_t;

    omc_wake_st_t st_q, st_d;

    always_comb
    begin
        st_d = st_q;
        st_d.on = evt.power_on_request_pin | evt.reset_request | evt.rtc_alarm;
        st_d.wake = evt.paging_wake | evt.rtc_alarm
                  | (evt.uart_wake && psv_setting == OMC_PSV_UART_1);
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign switch_on_cause = st_q.on;
    assign idle_wake       = st_q.wake;
endmodule

// File: verilog/omc_clksel.sv
`timescale 1ns/10ps
// core clock source and rtc run decision per mode
// assumes variant code static after reset
module omc_clksel
    import omc_pkg::*;
(
    // inputs
    input  wire omc_pkg::omc_mode_t mode,
    input  wire logic [1:0]        slow_variant,
    input  wire logic              backup_supply_rail,
    // outputs
    output omc_pkg::omc_clk_t      core_clk,
    output logic                   ext_a_used,
    output logic                   ext_b_used,
    output logic                   rtc_running
);
    import omc_pkg::*;

    always_comb
    begin
        core_clk   = OMC_CLK_NONE;
        ext_a_used = 1'b0;
        ext_b_used = 1'b0;
        unique case (mode)
            OMC_IDLE:
            begin
                core_clk   = OMC_CLK_SLOW;
                ext_a_used = (slow_variant == OMC_SLOW_EXT_A);
                ext_b_used = (slow_variant == OMC_SLOW_EXT_B);
            end
            OMC_ACTIVE, OMC_CONNECTED: core_clk = OMC_CLK_FAST;
            default: core_clk = OMC_CLK_NONE;
        endcase
        // backup rail generated internally outside not-powered
        rtc_running = (mode != OMC_NOT_POWERED) || backup_supply_rail;
    end
endmodule

// File: verification/omc_host.sv
`timescale 1ns/10ps
// host model: drives event pulses and the power saving command
// assumes the bench calls its tasks; all changes land on falling edges
module omc_host
    import omc_pkg::*;
(
    // clocking
    input  wire logic          clock,
    // lines toward the controller
    output omc_pkg::omc_evt_t  evt,
    output omc_pkg::omc_cmd_t  cmd
);
    logic [8:0] pulse_v;
    logic       idle_lvl;

    assign evt = omc_evt_t'(pulse_v | {8'h00, idle_lvl});

    initial
    begin
        pulse_v  = 9'h000;
        idle_lvl = 1'b0;
        cmd      = '0;
    end

    // one-cycle pulse, released at the next falling edge
    task automatic send_evt(input int i);
        @(negedge clock);
        pulse_v = 9'(9'h001 << i);
        @(negedge clock);
        pulse_v = 9'h000;
    endtask

    // idle permission is a level, not a pulse
    task automatic set_idle(input logic v);
        @(negedge clock);
        idle_lvl = v;
    endtask

    task automatic send_cmd(input logic [1:0] s, input logic f);
        @(negedge clock);
        cmd = '{1'b1, s, f};
        @(negedge clock);
        cmd.valid = 1'b0;
    endtask
endmodule

// File: verification/testbench.sv
`timescale 1ns/10ps
// self-checking bench for the operating mode controller
// assumes omc_host supplies events; inputs change on falling edges
module testbench;
    import omc_pkg::*;
    logic        clock;
    logic        resetn;
    logic        supply_ok;
    logic        backup_supply_rail;
    logic [1:0]  slow_variant;
    omc_evt_t    evt;
    omc_cmd_t    cmd;
    omc_mode_t   mode;
    logic [1:0]  psv_setting;
    omc_status_t status;
    int          n_fail;
    int          compares;

    omc_top DUT (.clock(clock), .resetn(resetn), .supply_ok(supply_ok),
        .backup_supply_rail(backup_supply_rail), .slow_variant(slow_variant), .evt(evt),
        .power_saving_command(cmd), .mode(mode), .psv_setting(psv_setting),
        .status(status));
    omc_host host (.clock(clock), .evt(evt), .cmd(cmd));

    always #5 clock = ~clock;

    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic chk_mode(input omc_mode_t exp);
        compares++;
        if (mode !== exp)
        begin
            n_fail++;
            $display("unexpected mode at %0t: got %h expected %h", $time, mode, exp);
        end
    endtask

    task automatic chk_val(input logic [1:0] got, input logic [1:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic t_unpowered;
        chk_mode(OMC_NOT_POWERED);
        chk_val(psv_setting, 2'h0);
        host.send_evt(8);
        host.send_evt(7);
        host.send_evt(6);
        tick(1);
        chk_mode(OMC_NOT_POWERED);
        tick(2);
        chk_val({1'b0, status.rtc_running}, 2'h0);
        backup_supply_rail = 1'b1;
        tick(2);
        chk_val({1'b0, status.rtc_running}, 2'h1);
    endtask

    task automatic t_power_up;
        supply_ok = 1'b1;
        tick(1);
        chk_mode(OMC_ACTIVE);
        chk_val(status.core_clk, OMC_CLK_FAST);
        chk_val({1'b0, status.app_if_enable}, 2'h1);
        chk_val(psv_setting, 2'h0);
        chk_val({1'b0, status.uart_cts_n}, 2'h0);
    endtask

    task automatic t_call;
        host.send_evt(4);
        chk_mode(OMC_CONNECTED);
        chk_val(status.core_clk, OMC_CLK_FAST);
        host.send_evt(3);
        chk_mode(OMC_ACTIVE);
    endtask

    // each slow variant paired with a different wake cause
    task automatic t_idle;
        int wake [3] = '{2, 1, 6};
        host.set_idle(1'b1);
        tick(2);
        chk_mode(OMC_ACTIVE);
        host.set_idle(1'b0);
        for (int v = 0; v < 3; v++)
        begin
            slow_variant = 2'(v);
            host.send_cmd(OMC_PSV_UART_1, 1'b1);
            chk_val(psv_setting, OMC_PSV_UART_1);
            chk_val({1'b0, status.app_if_enable}, 2'h0);
            host.set_idle(1'b1);
            tick(1);
            chk_mode(OMC_IDLE);
            chk_val(status.core_clk, OMC_CLK_SLOW);
            chk_val({1'b0, status.slow_ext_a_used}, {1'b0, v == 1});
            chk_val({1'b0, status.slow_ext_b_used}, {1'b0, v == 2});
            chk_val({1'b0, status.app_if_enable}, 2'h0);
            chk_val({1'b0, status.uart_cts_n}, 2'h1);
            host.set_idle(1'b0);
            host.send_evt(wake[v]);
            tick(1);
            chk_mode(OMC_ACTIVE);
        end
        // without flow control cts stays low even in idle
        host.send_cmd(OMC_PSV_UART_1, 1'b0);
        host.set_idle(1'b1);
        tick(1);
        chk_mode(OMC_IDLE);
        chk_val({1'b0, status.uart_cts_n}, 2'h0);
        host.set_idle(1'b0);
        host.send_evt(2);
        tick(1);
        chk_mode(OMC_ACTIVE);
        host.send_cmd(OMC_PSV_OFF, 1'b1);
        chk_val(psv_setting, OMC_PSV_OFF);
        chk_val({1'b0, status.app_if_enable}, 2'h1);
        chk_val({1'b0, status.uart_cts_n}, 2'h0);
    endtask

    task automatic t_power_off;
        int cause [3] = '{8, 7, 6};
        host.send_evt(5);
        chk_mode(OMC_POWER_OFF);
        chk_val(psv_setting, 2'h0);
        for (int i = 0; i < 3; i++)
        begin
            host.send_evt(cause[i]);
            tick(1);
            chk_mode(OMC_ACTIVE);
            host.send_evt(5);
            chk_mode(OMC_POWER_OFF);
        end
        supply_ok = 1'b0;
        tick(1);
        chk_mode(OMC_NOT_POWERED);
    endtask

    task automatic t_loss;
        supply_ok = 1'b1;
        tick(1);
        host.send_evt(4);
        chk_mode(OMC_CONNECTED);
        supply_ok = 1'b0;
        tick(1);
        chk_mode(OMC_NOT_POWERED);
        chk_val(status.core_clk, OMC_CLK_NONE);
    endtask

    task automatic test_done;
        $display("comparisons %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // whole run is under a hundred cycles; this cuts a hang short
    initial
    begin
        #20000;
        n_fail++;
        test_done();
    end

    initial
    begin
        clock              = 1'b0;
        resetn             = 1'b0;
        supply_ok          = 1'b0;
        backup_supply_rail = 1'b0;
        slow_variant       = 2'h0;
        n_fail             = 0;
        compares           = 0;
        tick(3);
        resetn = 1'b1;
        t_unpowered();
        t_power_up();
        t_call();
        t_idle();
        t_power_off();
        t_loss();
        test_done();
    end
endmodule
